// ===== core/nvmsac_ctrl.v
// Nonvolatile memory section access controller
// Assumes one access at a time from core or programming port, and an
// array that answers reads in the same cycle and pulses done per memory
//
// Contract
// R1: Code fuse not above boot: no code section
// R2: Fuses count 512-byte blocks; zero sizes special
// R3: Boundary past flash end uses default fuse
// R4: Boot read-protect set in boot, acts outside
// R5: Write-protect bits lock code and data sections
// R6: EEPROM 512 bytes, erase 1..32, byte writes
// R7: Identification row rejects writes and erases
// R8: User row is 32 bytes, survives chip erase
// R9: Port reads user row only when unlocked
// R10: Fuses load at start-up, written by port only
// R11: Flash at 0x0000 code, 0x8000 data space
// R12: Code address is page register over pointer
// R13: Code read byte chosen by address bit 0
// R14: Target address captured when operation starts
// R15: Window select maps 32 KB flash block
// R16: Access during erase or write stalls bus
// R17: Data stores byte, program store word only
// R18: One erase covers up to 32 pages
// R19: Flash page holds 512 bytes
// R20: User row erased whole, written per byte; a store from the programming port while locked writes the whole 32-byte row
// R21: Whole erases start at once, others arm
// R22: Software checks busy, keys, commands within four
// R23: Software writes no-operation after stores
// R24: Busy flags stand for whole operation
// R25: Command write outside key window ignored
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "nvmsac_map.vh"
module nvmsac_ctrl #(
	parameter FLASH_PAGES = 256,
	parameter FA_W = 17
) (
	input wire clk_sys_i,
	input wire reset_n_i,
	input wire [7:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	input wire fuse_load_i,
	input wire [7:0] fuse_boot_i,
	input wire [7:0] fuse_code_i,
	input wire [FA_W-1:0] exec_pc_i,
	input wire dev_locked_i,
	input wire acc_req_i,
	input wire acc_we_i,
	input wire acc_pm_i,
	input wire acc_pp_i,
	input wire [15:0] acc_addr_i,
	input wire [15:0] acc_wdata_i,
	output wire acc_stall_o,
	output reg acc_rvalid_o,
	output reg [7:0] acc_rdata_o,
	output wire [FA_W-1:0] arr_raddr_o,
	output wire [2:0] arr_rsel_o,
	input wire [15:0] arr_rdata_i,
	output reg op_valid_o,
	output reg [2:0] op_target_o,
	output reg [2:0] op_kind_o,
	output reg [2:0] op_span_o,
	output reg [FA_W-1:0] op_addr_o,
	output reg [15:0] op_data_o,
	input wire flash_done_i,
	input wire ee_done_i,
	output wire flash_busy_o,
	output wire eeprom_busy_o
);
	reg [7:0] cmd_r;
	reg rp_r;
	reg wpc_r;
	reg wpd_r;
	reg [1:0] flash_window_select_r;
	reg [7:0] ext_r;
	reg [2:0] key_cnt_r;
	reg [7:0] fboot_r;
	reg [7:0] fcode_r;
	reg flash_busy_flag_r;
	reg eeprom_busy_flag_r;
	reg [7:0] rd_nxt;
	wire x_boot;
	wire x_code;
	wire x_data;
	wire a_boot;
	wire a_code;
	wire a_data;

	// Register port decode
	wire key_wr = reg_wr_i && (reg_addr_i == `NVMSAC_REG_KEY);
	wire cmd_wr = reg_wr_i && (reg_addr_i == `NVMSAC_REG_CMD) &&
		(key_cnt_r != 3'h0); // R25
	wire prot_wr = reg_wr_i && (reg_addr_i == `NVMSAC_REG_PROT);
	wire ext_wr = reg_wr_i && (reg_addr_i == `NVMSAC_REG_EXTPG);
	wire imm_whole_chip_erase = cmd_wr && (reg_wdata_i == `NVMSAC_CMD_WHOLE_CHIP_ERASE);
	wire imm_whole_eeprom_erase = cmd_wr && (reg_wdata_i == `NVMSAC_CMD_WHOLE_EEPROM_ERASE);
	wire imm_go = imm_whole_chip_erase || imm_whole_eeprom_erase;

	// Access address forming
	wire [23:0] pm_full = {ext_r, acc_addr_i}; // R12
	wire [23:0] ds_full = {7'h00, flash_window_select_r, acc_addr_i[14:0]}; // R15
	wire [23:0] da_full = {8'h00, acc_addr_i};
	wire is_fl = acc_pm_i || acc_addr_i[15]; // R11
	wire [23:0] fa_full = acc_pm_i ? pm_full : ds_full; // R11
	wire [FA_W-1:0] fa = fa_full[FA_W-1:0];
	wire is_ee = !acc_pm_i && (acc_addr_i[15:9] == `NVMSAC_EE_SEL); // R6
	wire is_ur = !acc_pm_i && (acc_addr_i[15:5] == `NVMSAC_UR_SEL); // R8
	wire is_sig = !acc_pm_i && (acc_addr_i[15:7] == `NVMSAC_SIG_SEL);
	wire is_fuse = !acc_pm_i && (acc_addr_i[15:4] == `NVMSAC_FUSE_SEL);
	wire hit = is_fl || is_ee || is_ur || is_sig || is_fuse;
	wire [2:0] tgt = is_fl ? `NVMSAC_TGT_FL :
		is_ee ? `NVMSAC_TGT_EE :
		is_ur ? `NVMSAC_TGT_UR :
		is_fuse ? `NVMSAC_TGT_FUSE : `NVMSAC_TGT_SIG;

	nvmsac_sect #(
		.FLASH_PAGES(FLASH_PAGES),
		.FA_W(FA_W)
	) u_exec_sect (
		.boot_i(fboot_r),
		.code_i(fcode_r),
		.addr_i(exec_pc_i),
		.in_boot_o(x_boot),
		.in_code_o(x_code),
		.in_data_o(x_data)
	);

	nvmsac_sect #(
		.FLASH_PAGES(FLASH_PAGES),
		.FA_W(FA_W)
	) u_acc_sect (
		.boot_i(fboot_r),
		.code_i(fcode_r),
		.addr_i(fa),
		.in_boot_o(a_boot),
		.in_code_o(a_code),
		.in_data_o(a_data)
	);

	// Bus wait while any erase or write runs
	wire busy_any = flash_busy_flag_r || eeprom_busy_flag_r;
	assign acc_stall_o = acc_req_i && (busy_any || imm_go); // R16
	wire take = acc_req_i && !busy_any && !imm_go;
	assign flash_busy_o = flash_busy_flag_r;
	assign eeprom_busy_o = eeprom_busy_flag_r;

	// Read path
	assign arr_raddr_o = is_fl ? fa : da_full[FA_W-1:0];
	assign arr_rsel_o = tgt;
	// Boot protection acts only once execution is outside boot
	wire rd_block = (is_fl && a_boot && rp_r && !x_boot) || // R4
		(is_ur && acc_pp_i && dev_locked_i); // R9
	wire [7:0] rd_byte = (is_fl && fa[0]) ? arr_rdata_i[15:8] :
		arr_rdata_i[7:0]; // R13

	// Armed command decode
	wire c_flw = (cmd_r == `NVMSAC_CMD_FLWR);
	wire c_fer = (cmd_r[7:3] == `NVMSAC_CMD_FLER_GRP) &&
		(cmd_r[2:0] <= `NVMSAC_SPAN_MAX); // R18
	wire c_eew = (cmd_r == `NVMSAC_CMD_EEWR);
	wire c_eerw = (cmd_r == `NVMSAC_CMD_EEERWR); // R6
	wire c_eer = (cmd_r[7:3] == `NVMSAC_CMD_EEER_GRP) &&
		(cmd_r[2:0] <= `NVMSAC_SPAN_MAX); // R6
	wire c_ee = c_eew || c_eerw || c_eer;
	wire c_fl = c_flw || c_fer;

	// Self-programming permission by executing and target section
	wire fl_ok_cpu = a_boot ? 1'b0 :
		a_code ? (x_boot && !wpc_r) : // R5
		((x_boot || x_code) && !wpd_r && a_data); // R5
	wire fl_ok = acc_pp_i || fl_ok_cpu;
	wire ee_ok = acc_pp_i || !x_data;
	wire wr_fl = is_fl && c_fl && fl_ok;
	wire wr_ee = is_ee && c_ee && ee_ok && !acc_pm_i; // R17
	wire wr_ur = is_ur && c_fl; // R9
	wire wr_fuse = is_fuse && c_ee && acc_pp_i; // R10
	// Identification row never matches a write path
	wire wr_any = wr_fl || wr_ee || wr_ur || wr_fuse; // R7
	wire start = take && acc_we_i && wr_any; // R21
	wire on_flash = wr_fl || wr_ur;

	// Operation shape
	wire ur_page = acc_pp_i && dev_locked_i;
	reg [2:0] kind_nxt;
	reg [2:0] span_nxt;
	reg [3:0] clr_nxt;
	always @* begin
		kind_nxt = `NVMSAC_OP_BYTE;
		span_nxt = 3'h0;
		clr_nxt = 4'h0;
		if (on_flash) begin
			if (c_flw) begin
				kind_nxt = acc_pm_i ? `NVMSAC_OP_WORD : `NVMSAC_OP_BYTE; // R17
				clr_nxt = acc_pm_i ? 4'h1 : 4'h0; // R12
				if (wr_ur && ur_page) begin
					span_nxt = `NVMSAC_SPAN_MAX; // R20
					clr_nxt = `NVMSAC_UR_SH;
				end
			end else if (wr_ur) begin
				kind_nxt = `NVMSAC_OP_ERASE;
				span_nxt = `NVMSAC_SPAN_MAX; // R20
				clr_nxt = `NVMSAC_UR_SH;
			end else begin
				kind_nxt = `NVMSAC_OP_ERASE;
				span_nxt = cmd_r[2:0]; // R18
				clr_nxt = `NVMSAC_PAGE_SH + {1'b0, cmd_r[2:0]}; // R19
			end
		end else begin
			if (c_eerw) begin
				kind_nxt = `NVMSAC_OP_ERWR;
			end else if (c_eer && wr_ee) begin
				kind_nxt = `NVMSAC_OP_ERASE;
				span_nxt = cmd_r[2:0]; // R6
				clr_nxt = {1'b0, cmd_r[2:0]};
			end
		end
	end
	wire [23:0] base_full = is_fl ? fa_full : da_full;
	wire [23:0] amask = ~((24'h000001 << clr_nxt) - 24'h000001);
	wire [23:0] tgt_addr = base_full & amask;

	// Control and protection registers
	always @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			cmd_r <= `NVMSAC_CMD_NO_COMMAND;
			key_cnt_r <= 3'h0;
			rp_r <= 1'b0;
			wpc_r <= 1'b0;
			wpd_r <= 1'b0;
			flash_window_select_r <= 2'h0;
			ext_r <= 8'h00;
		end else begin
			if (key_wr && (reg_wdata_i == `NVMSAC_KEY_VAL)) begin
				key_cnt_r <= `NVMSAC_KEY_WIN; // R25
			end else if (cmd_wr) begin
				key_cnt_r <= 3'h0;
			end else if (key_cnt_r != 3'h0) begin
				key_cnt_r <= key_cnt_r - 3'h1;
			end
			if (cmd_wr) begin
				cmd_r <= reg_wdata_i; // R21
			end
			if (prot_wr) begin
				if (reg_wdata_i[`NVMSAC_PROT_RP] && x_boot) begin
					rp_r <= 1'b1; // R4
				end
				if (reg_wdata_i[`NVMSAC_PROT_WPC]) begin
					wpc_r <= 1'b1; // R5
				end
				if (reg_wdata_i[`NVMSAC_PROT_WPD]) begin
					wpd_r <= 1'b1; // R5
				end
				flash_window_select_r <= reg_wdata_i[`NVMSAC_PROT_MAP_LO+1:`NVMSAC_PROT_MAP_LO]; // R15
			end
			if (ext_wr) begin
				ext_r <= reg_wdata_i; // R12
			end
		end
	end

	// Section fuses are taken once start-up finishes
	always @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			fboot_r <= 8'h00;
			fcode_r <= 8'h00;
		end else if (fuse_load_i) begin
			fboot_r <= fuse_boot_i; // R10
			fcode_r <= fuse_code_i; // R10
		end
	end

	// Busy flags; a new start wins over a done in the same cycle
	always @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			flash_busy_flag_r <= 1'b0;
			eeprom_busy_flag_r <= 1'b0;
		end else begin
			flash_busy_flag_r <= (start && on_flash) || imm_whole_chip_erase ||
				(flash_busy_flag_r && !flash_done_i); // R24
			eeprom_busy_flag_r <= (start && !on_flash) || imm_go ||
				(eeprom_busy_flag_r && !ee_done_i); // R24
		end
	end

	// Operation request, address captured at start
	always @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			op_valid_o <= 1'b0;
			op_target_o <= `NVMSAC_TGT_FL;
			op_kind_o <= `NVMSAC_OP_BYTE;
			op_span_o <= 3'h0;
			op_addr_o <= {FA_W{1'b0}};
			op_data_o <= 16'h0000;
		end else begin
			op_valid_o <= start || imm_go;
			if (imm_go) begin
				// Whole-chip erase covers flash and EEPROM, never the user row
				op_target_o <= imm_whole_chip_erase ? `NVMSAC_TGT_FL : `NVMSAC_TGT_EE; // R8
				op_kind_o <= `NVMSAC_OP_WHOLE; // R21
				op_span_o <= 3'h0;
				op_addr_o <= {FA_W{1'b0}};
				op_data_o <= 16'h0000;
			end else if (start) begin
				op_target_o <= tgt;
				op_kind_o <= kind_nxt;
				op_span_o <= span_nxt;
				op_addr_o <= tgt_addr[FA_W-1:0]; // R14
				op_data_o <= acc_pm_i ? acc_wdata_i :
					{8'h00, acc_wdata_i[7:0]}; // R17
			end
		end
	end

	// Read answers, one cycle after the request is taken
	always @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			acc_rvalid_o <= 1'b0;
			acc_rdata_o <= 8'h00;
		end else begin
			acc_rvalid_o <= take && !acc_we_i;
			if (take && !acc_we_i) begin
				acc_rdata_o <= (rd_block || !hit) ? 8'h00 : rd_byte; // R7 R10
			end
		end
	end

	// Register read mux
	always @* begin
		case (reg_addr_i)
			`NVMSAC_REG_CMD: rd_nxt = cmd_r;
			`NVMSAC_REG_PROT: rd_nxt = {2'h0, flash_window_select_r, 1'b0, wpd_r, wpc_r, rp_r};
			`NVMSAC_REG_STAT: rd_nxt = {6'h00, eeprom_busy_flag_r, flash_busy_flag_r}; // R24
			`NVMSAC_REG_EXTPG: rd_nxt = ext_r;
			`NVMSAC_REG_FBOOT: rd_nxt = fboot_r; // R10
			`NVMSAC_REG_FCODE: rd_nxt = fcode_r;
			default: rd_nxt = 8'h00;
		endcase
	end

	always @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			reg_rdata_o <= 8'h00;
		end else begin
			reg_rdata_o <= reg_rd_i ? rd_nxt : 8'h00;
		end
	end
endmodule

// ===== core/nvmsac_map.vh
// Register offsets, field positions, command codes and address decodes
// Assumes an 8-bit register port and a 16-bit data-space address
`ifndef NVMSAC_MAP_VH
`define NVMSAC_MAP_VH
`define NVMSAC_REG_CMD 8'h00
`define NVMSAC_REG_PROT 8'h01
`define NVMSAC_REG_STAT 8'h02
`define NVMSAC_REG_KEY 8'h03
`define NVMSAC_REG_EXTPG 8'h04
`define NVMSAC_REG_FBOOT 8'h05
`define NVMSAC_REG_FCODE 8'h06
`define NVMSAC_PROT_RP 0
`define NVMSAC_PROT_WPC 1
`define NVMSAC_PROT_WPD 2
`define NVMSAC_PROT_MAP_LO 4
`define NVMSAC_STAT_FLASH_BUSY_FLAG 0
`define NVMSAC_STAT_EEPROM_BUSY_FLAG 1
`define NVMSAC_KEY_VAL 8'h9D
`define NVMSAC_KEY_WIN 3'h4
`define NVMSAC_CMD_NO_COMMAND 8'h00
`define NVMSAC_CMD_NO_OPERATION_COMMAND 8'h01
`define NVMSAC_CMD_FLWR 8'h02
`define NVMSAC_CMD_FLER_GRP 5'h01
`define NVMSAC_CMD_EEWR 8'h12
`define NVMSAC_CMD_EEERWR 8'h13
`define NVMSAC_CMD_EEER_GRP 5'h03
`define NVMSAC_CMD_WHOLE_CHIP_ERASE 8'h20
`define NVMSAC_CMD_WHOLE_EEPROM_ERASE 8'h30
`define NVMSAC_SPAN_MAX 3'h5
`define NVMSAC_PAGE_SH 4'h9
`define NVMSAC_UR_SH 4'h5
`define NVMSAC_EE_SEL 7'h0A
`define NVMSAC_UR_SEL 11'h090
`define NVMSAC_SIG_SEL 9'h022
`define NVMSAC_FUSE_SEL 12'h105
`define NVMSAC_TGT_FL 3'h0
`define NVMSAC_TGT_EE 3'h1
`define NVMSAC_TGT_UR 3'h2
`define NVMSAC_TGT_FUSE 3'h3
`define NVMSAC_TGT_SIG 3'h4
`define NVMSAC_OP_BYTE 3'h0
`define NVMSAC_OP_WORD 3'h1
`define NVMSAC_OP_ERASE 3'h2
`define NVMSAC_OP_ERWR 3'h3
`define NVMSAC_OP_WHOLE 3'h4
`define NVMSAC_DEF_BOOT 8'h00
`define NVMSAC_DEF_CODE 8'h00
`endif

// ===== core/nvmsac_sect.v
// Flash section classifier: boot, application code or application data
// Assumes fuse sizes in 512-byte pages, loaded once after start-up
`timescale 1ns/10ps
`include "nvmsac_map.vh"
module nvmsac_sect #(
	parameter FLASH_PAGES = 256,
	parameter FA_W = 17
) (
	input wire [7:0] boot_i,
	input wire [7:0] code_i,
	input wire [FA_W-1:0] addr_i,
	output wire in_boot_o,
	output wire in_code_o,
	output wire in_data_o
);
	localparam [15:0] PAGES = FLASH_PAGES;
	wire [15:0] pg;
	wire [15:0] boot_w;
	wire [15:0] code_w;
	wire [7:0] eff_boot;
	wire [7:0] eff_code;
	wire has_code;
	assign pg = {{(25-FA_W){1'b0}}, addr_i[FA_W-1:9]};
	assign boot_w = {8'h00, boot_i};
	assign code_w = {8'h00, code_i};
	// Boundary past the flash end falls back to the default
	assign eff_boot = (boot_w > PAGES) ? `NVMSAC_DEF_BOOT : boot_i; // R3
	assign eff_code = (code_w > PAGES) ? `NVMSAC_DEF_CODE : code_i; // R3
	// Zero boot size makes all flash boot
	assign in_boot_o = (eff_boot == 8'h00) || (pg < {8'h00, eff_boot}); // R2
	// Nonzero code size not above boot size, or a zero boot size, removes the code section
	assign has_code = (eff_boot != 8'h00) &&
		((eff_code == 8'h00) || (eff_code > eff_boot)); // R1 R2
	assign in_code_o = !in_boot_o && has_code &&
		((eff_code == 8'h00) || (pg < {8'h00, eff_code})); // R2
	assign in_data_o = !in_boot_o && !in_code_o; // R1
endmodule

// ===== verification/nvmsac_chk.sv
// Port checker for the section access controller
// Assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
module nvmsac_chk #(
	parameter FA_W = 17
) (
	input wire clk_sys_i,
	input wire reset_n_i,
	input wire acc_req_i,
	input wire acc_we_i,
	input wire acc_stall_o,
	input wire acc_rvalid_o,
	input wire op_valid_o,
	input wire [2:0] op_target_o,
	input wire [2:0] op_kind_o,
	input wire [FA_W-1:0] op_addr_o,
	input wire flash_done_i,
	input wire flash_busy_o,
	input wire eeprom_busy_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);
	sequence s_load;
		acc_req_i && !acc_we_i && !acc_stall_o;
	endsequence
	sequence s_quiet;
		!op_valid_o [*2];
	endsequence
	AST_STALL: assert property (acc_req_i && (flash_busy_o || eeprom_busy_o) |-> acc_stall_o)
		else $error("load or store not stalled while busy");
	AST_NOSTALL: assert property (!acc_req_i |-> !acc_stall_o)
		else $error("stall without request");
	AST_RVALID: assert property (s_load |=> acc_rvalid_o)
		else $error("load data missing");
	AST_RV_CAUSE: assert property (acc_rvalid_o |-> $past(acc_req_i && !acc_we_i && !acc_stall_o))
		else $error("load data without load");
	AST_F_BUSY: assert property (op_valid_o && op_target_o[2:1] == 2'h0 && !op_target_o[0]
		|-> flash_busy_o)
		else $error("flash op without flash busy");
	AST_E_BUSY: assert property (op_valid_o && op_target_o == 3'h1 |-> eeprom_busy_o)
		else $error("eeprom op without eeprom busy");
	AST_F_HOLD: assert property (flash_busy_o && !flash_done_i |=> flash_busy_o)
		else $error("flash busy dropped early");
	AST_WORD: assert property (op_valid_o && op_kind_o == 3'h1 |-> !op_addr_o[0])
		else $error("word write address odd");
	AST_OP_GAP: assert property (op_valid_o |=> s_quiet)
		else $error("operation started while busy");
endmodule
bind nvmsac_ctrl nvmsac_chk #(.FA_W(FA_W)) u_chk (.clk_sys_i, .reset_n_i, .acc_req_i,
	.acc_we_i, .acc_stall_o, .acc_rvalid_o, .op_valid_o, .op_target_o, .op_kind_o,
	.op_addr_o, .flash_done_i, .flash_busy_o, .eeprom_busy_o);

// ===== verification/nvmsac_arr_model.sv
// Memory array stand-in: same-cycle read word, late done pulses
// Assumes one operation at a time on each memory
`timescale 1ns/10ps
module nvmsac_arr_model (
	input wire clk_sys_i,
	input wire reset_n_i,
	input wire [16:0] arr_raddr_o,
	input wire op_valid_o,
	input wire [2:0] op_target_o,
	input wire [31:0] dly_i,
	output wire [15:0] arr_rdata_i,
	output logic flash_done_i = 1'b0,
	output logic ee_done_i = 1'b0
);
	logic [31:0] f_cnt_r = 32'h0;
	logic [31:0] e_cnt_r = 32'h0;
	wire [7:0] lo = arr_raddr_o[16:9] ^ {arr_raddr_o[7:1], 1'b0};
	assign arr_rdata_i = {~lo, lo};
	always @(posedge clk_sys_i) begin
		flash_done_i <= reset_n_i && f_cnt_r == 32'h1;
		ee_done_i <= reset_n_i && e_cnt_r == 32'h1;
		if (!reset_n_i) begin
			f_cnt_r <= 32'h0;
			e_cnt_r <= 32'h0;
		end else if (op_valid_o && op_target_o[0]) begin
			e_cnt_r <= dly_i;
		end else if (op_valid_o) begin
			f_cnt_r <= dly_i;
		end else begin
			f_cnt_r <= f_cnt_r - (f_cnt_r != 32'h0);
			e_cnt_r <= e_cnt_r - (e_cnt_r != 32'h0);
		end
	end
endmodule

// ===== verification/tb_top.sv
// Bench for the section access controller
// Assumes the array model and the bound port checker
`timescale 1ns/10ps
`include "nvmsac_map.vh"
module tb_top;
	logic clk_sys_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic fuse_load_i = 1'b0, dev_locked_i = 1'b0, acc_req_i = 1'b0, acc_we_i = 1'b0;
	logic acc_pm_i = 1'b0, acc_pp_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, fuse_boot_i = 8'h00;
	logic [7:0] fuse_code_i = 8'h00, q;
	logic [16:0] exec_pc_i = 17'h00000, l_addr;
	logic [15:0] acc_addr_i = 16'h0000, acc_wdata_i = 16'h0000;
	logic [21:0] l_op;
	logic [2:0] l_span;
	logic [31:0] dly = 32'd20, n, k;
	int num_errors = 0, samples_checked = 0, n_ops = 0;
	wire [7:0] reg_rdata_o, acc_rdata_o;
	wire [16:0] arr_raddr_o, op_addr_o;
	wire [15:0] arr_rdata_i, op_data_o;
	wire [2:0] arr_rsel_o, op_target_o, op_kind_o, op_span_o;
	wire acc_stall_o, acc_rvalid_o, op_valid_o, flash_done_i, ee_done_i;
	wire flash_busy_o, eeprom_busy_o;
	nvmsac_ctrl dut (.clk_sys_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o, .fuse_load_i, .fuse_boot_i, .fuse_code_i, .exec_pc_i,
		.dev_locked_i, .acc_req_i, .acc_we_i, .acc_pm_i, .acc_pp_i, .acc_addr_i,
		.acc_wdata_i, .acc_stall_o, .acc_rvalid_o, .acc_rdata_o, .arr_raddr_o,
		.arr_rsel_o, .arr_rdata_i, .op_valid_o, .op_target_o, .op_kind_o, .op_span_o,
		.op_addr_o, .op_data_o, .flash_done_i, .ee_done_i, .flash_busy_o, .eeprom_busy_o);
	nvmsac_arr_model u_arr (.clk_sys_i, .reset_n_i, .arr_raddr_o, .op_valid_o,
		.op_target_o, .dly_i(dly), .arr_rdata_i, .flash_done_i, .ee_done_i);
	initial forever #4 clk_sys_i = ~clk_sys_i;
	// Captured mid-cycle so a task returning on the next edge sees it
	always @(negedge clk_sys_i) if (op_valid_o === 1'b1) begin
		n_ops++;
		l_op = {op_target_o, op_kind_o, op_data_o};
		l_span = op_span_o;
		l_addr = op_addr_o;
	end
	function logic [7:0] fl(input logic [16:0] a);
		return a[16:9] ^ {a[7:1], 1'b0};
	endfunction
	task chk(input string nm, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task wr(input logic [7:0] a, d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task rd(input logic [7:0] a);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_sys_i);
		q = reg_rdata_o;
		@(posedge clk_sys_i);
	endtask
	task rchk(input string nm, input logic [7:0] a, e);
		rd(a);
		chk(nm, q, e);
	endtask
	// Waits for both busy flags to clear, then keys and writes the command
	task cmd(input logic [7:0] c);
		n = 0;
		do begin
			rd(`NVMSAC_REG_STAT);
			n++;
		end while (q !== 8'h00 && n < 50);
		if (n >= 50) begin
			num_errors++;
			complete_run;
		end
		wr(`NVMSAC_REG_KEY, `NVMSAC_KEY_VAL);
		wr(`NVMSAC_REG_CMD, c);
	endtask
	task acc(input logic we, pm, pp, input logic [15:0] a, d);
		acc_we_i <= we;
		acc_pm_i <= pm;
		acc_pp_i <= pp;
		acc_addr_i <= a;
		acc_wdata_i <= d;
		acc_req_i <= 1'b1;
		n = 0;
		do begin
			@(negedge clk_sys_i);
			n++;
		end while (acc_stall_o !== 1'b0 && n < 300);
		if (n >= 300) begin
			num_errors++;
			complete_run;
		end
		@(posedge clk_sys_i);
		acc_req_i <= 1'b0;
		@(negedge clk_sys_i);
		q = acc_rdata_o;
		chk("rvalid", acc_rvalid_o, !we);
		@(posedge clk_sys_i);
	endtask
	initial begin
		repeat (5) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		fuse_boot_i <= 8'h04;
		fuse_code_i <= 8'h08;
		fuse_load_i <= 1'b1;
		@(posedge clk_sys_i);
		fuse_load_i <= 1'b0;
		@(posedge clk_sys_i);
		rchk("stat", `NVMSAC_REG_STAT, 8'h00);
		rchk("prot", `NVMSAC_REG_PROT, 8'h00);
		rchk("fboot", `NVMSAC_REG_FBOOT, 8'h04);
		wr(`NVMSAC_REG_FCODE, 8'hFF);
		rchk("fcode", `NVMSAC_REG_FCODE, 8'h08);
		$display("reset and fuse test done");
		wr(`NVMSAC_REG_CMD, `NVMSAC_CMD_FLWR);
		rchk("cmd unkeyed", `NVMSAC_REG_CMD, 8'h00);
		wr(`NVMSAC_REG_KEY, `NVMSAC_KEY_VAL);
		repeat (4) @(posedge clk_sys_i);
		wr(`NVMSAC_REG_CMD, `NVMSAC_CMD_FLWR);
		rchk("cmd late", `NVMSAC_REG_CMD, 8'h00);
		$display("key window test done");
		wr(`NVMSAC_REG_EXTPG, 8'h01);
		acc(1'b0, 1'b1, 1'b0, 16'h0003, 16'h0000);
		chk("code read hi", q, {~fl(17'h10003)});
		acc(1'b0, 1'b1, 1'b0, 16'h0002, 16'h0000);
		chk("code read lo", q, fl(17'h10002));
		wr(`NVMSAC_REG_EXTPG, 8'h00);
		wr(`NVMSAC_REG_PROT, 8'h10);
		acc(1'b0, 1'b0, 1'b0, 16'h8011, 16'h0000);
		// Odd data-space byte sits in the high half of the array word
		chk("data window", q, {~fl(17'h08011)});
		$display("read test done");
		cmd(`NVMSAC_CMD_FLWR);
		acc(1'b1, 1'b1, 1'b0, 16'h0A01, 16'hBEEF);
		rchk("flash busy", `NVMSAC_REG_STAT, 8'h01);
		chk("word op", l_op, {`NVMSAC_TGT_FL, `NVMSAC_OP_WORD, 16'hBEEF});
		acc(1'b0, 1'b1, 1'b0, 16'h0100, 16'h0000);
		chk("stalled", n > 32'd8, 1'b1);
		chk("latched addr", l_addr, 17'h00A00);
		cmd(`NVMSAC_CMD_NO_OPERATION_COMMAND);
		cmd(`NVMSAC_CMD_FLWR);
		acc(1'b1, 1'b0, 1'b0, 16'h8011, 16'h005A);
		chk("byte op", {l_op[21:16], l_op[7:0]}, {3'h0, `NVMSAC_OP_BYTE, 8'h5A});
		wr(`NVMSAC_REG_PROT, 8'h14);
		k = n_ops;
		acc(1'b1, 1'b0, 1'b0, 16'h8013, 16'h0011);
		chk("data protected", n_ops, k);
		cmd(`NVMSAC_CMD_NO_OPERATION_COMMAND);
		$display("flash write test done");
		cmd(`NVMSAC_CMD_WHOLE_EEPROM_ERASE);
		chk("whole erase", l_op[21:16], {`NVMSAC_TGT_EE, `NVMSAC_OP_WHOLE});
		rchk("ee busy", `NVMSAC_REG_STAT, 8'h02);
		dly = 32'd1;
		cmd(`NVMSAC_CMD_EEWR);
		k = n_ops;
		acc(1'b1, 1'b0, 1'b1, 16'h1100, 16'h0033);
		chk("id row", n_ops, k);
		acc(1'b1, 1'b0, 1'b0, 16'h1405, 16'h0044);
		chk("ee op", {l_op[21:16], l_op[7:0]}, {`NVMSAC_TGT_EE, `NVMSAC_OP_BYTE, 8'h44});
		cmd(`NVMSAC_CMD_NO_OPERATION_COMMAND);
		$display("eeprom test done");
		cmd(8'h0B);
		acc(1'b1, 1'b1, 1'b1, 16'h1E34, 16'h0000);
		chk("erase op", {l_op[21:16], l_span}, {`NVMSAC_TGT_FL, `NVMSAC_OP_ERASE, 3'h3});
		chk("erase addr", l_addr, 17'h01000);
		cmd(`NVMSAC_CMD_NO_OPERATION_COMMAND);
		$display("erase test done");
		complete_run;
	end
endmodule
